// [hdl/ffl_belt_field.sv]
// One 12-bit latency tolerance field with its configuration image.
// Assumes loader pulses and resets are synchronous to clk.
`timescale 1ns/10ps
`include "ffl_regs.svh"
module ffl_belt_field (
  input logic clk,
  input logic rst,
  input logic load,
  input logic load_eeprom,
  input logic [11:0] load_data,
  input logic restore,
  input logic sw_we,
  input logic [11:0] sw_data,
  output logic [11:0] value
);

  logic [11:0] img_r;
  logic [11:0] img_nxt;
  logic [11:0] val_r;
  logic [11:0] val_nxt;
  logic eep_r;
  logic eep_nxt;
  logic take;

  // Memory image wins over otp once loaded, whatever the load order
  assign take = load && (load_eeprom || !eep_r);

  // Load beats restore beats software write
  always_comb begin
    img_nxt = img_r;
    val_nxt = val_r;
    eep_nxt = eep_r;
    if (take) begin
      img_nxt = load_data;
      val_nxt = load_data;
      eep_nxt = eep_r | load_eeprom;
    end else if (restore) begin
      val_nxt = img_r;
    end else if (sw_we) begin
      val_nxt = sw_data;
    end
  end

  // No image yet means zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      img_r <= `FFL_BELT_RST;
      val_r <= `FFL_BELT_RST;
      eep_r <= 1'b0;
    end else begin
      img_r <= img_nxt;
      val_r <= val_nxt;
      eep_r <= eep_nxt;
    end
  end

  assign value = val_r;

  property p_restore;
    @(posedge clk) disable iff (rst)
    restore && !load |=> value == $past(img_r);
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore did not bring back the image");

  property p_eeprom_load;
    @(posedge clk) disable iff (rst)
    load && load_eeprom |=> value == $past(load_data);
  endproperty
  a_eeprom_load: assert property (p_eeprom_load)
    else $error("memory image not taken");

  property p_otp_yields;
    @(posedge clk) disable iff (rst)
    eep_r && load && !load_eeprom && !restore && !sw_we |=> value == $past(value);
  endproperty
  a_otp_yields: assert property (p_otp_yields)
    else $error("otp value overrode memory image");

endmodule

// [hdl/ffl_config_regs.sv]
// APB register bank: transmit buffer sizing, pause watermarks, occupancy
// and latency tolerance selection. Assumes a zero-wait APB master on clk.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "ffl_regs.svh"
module ffl_config_regs (
  input logic clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic usb_reset,
  input logic lite_soft_reset,
  input logic belt_load,
  input logic belt_load_eeprom,
  input logic [2:0] belt_load_idx,
  input logic [11:0] belt_load_data,
  input ffl_pkg::ffl_ltm_t latency_state,
  input ffl_pkg::ffl_speed_t link_speed,
  output logic [11:0] belt_value,
  input logic rx_store,
  input logic [15:0] rx_store_len,
  input logic [7:0] rx_store_extra,
  input logic rx_drain,
  input logic [15:0] rx_drain_bytes,
  input logic [15:0] usb_out_queue_fill,
  input logic [15:0] usb_in_queue_fill,
  input logic [15:0] tx_buffer_fill,
  input logic pause_transmit_enable,
  output logic pause_request,
  output logic [15:0] rx_buffer_fill_bytes,
  output logic [5:0] tx_buffer_end_field,
  output logic [12:0] tx_buffer_last_addr
);

  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd_word;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic perr_r;
  logic perr_nxt;
  logic [5:0] tx_end_r;
  logic [5:0] tx_end_nxt;
  logic [12:0] last_r;
  logic [12:0] last_nxt;
  logic [6:0] wm_on_r;
  logic [6:0] wm_on_nxt;
  logic [6:0] wm_off_r;
  logic [6:0] wm_off_nxt;
  logic pause_r;
  logic pause_nxt;
  logic [15:0] fill_r;
  logic [15:0] fill_nxt;
  logic [15:0] store_bytes;
  logic [6:0] fill_units;
  logic [15:0] rx_total;
  logic [15:0] tx_total;
  logic [11:0] belt_r;
  logic [11:0] belt_nxt;
  logic [11:0] belt_fld [6];
  logic [11:0] belt_wdata [6];
  logic belt_we [6];
  logic restore;

  // Zero wait states; reads are prepared in the setup cycle
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign wr = pready && pwrite;
  assign restore = usb_reset || lite_soft_reset;

  // Occupancy sums wrap at 16 bits like the count fields
  assign rx_total = 16'(usb_out_queue_fill + fill_r);
  assign tx_total = 16'(usb_in_queue_fill + tx_buffer_fill);

  // Address decode and read word
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr == `FFL_OFF_TX_END) begin
      rd_word[`FFL_TX_END_MSB:0] = tx_end_r;
    end else if (paddr == `FFL_OFF_WMARK) begin
      rd_word[`FFL_WM_ON_MSB:`FFL_WM_ON_LSB] = wm_on_r;
      rd_word[`FFL_WM_OFF_MSB:`FFL_WM_OFF_LSB] = wm_off_r;
    end else if (paddr == `FFL_OFF_RX_OCC) begin
      rd_word = {rx_total, usb_out_queue_fill};
    end else if (paddr == `FFL_OFF_TX_OCC) begin
      rd_word = {tx_total, usb_in_queue_fill};
    end else if (paddr == `FFL_OFF_IDLE_FAST) begin
      rd_word[`FFL_HI_MSB:`FFL_HI_LSB] = belt_fld[0];
      rd_word[`FFL_LO_MSB:`FFL_LO_LSB] = belt_fld[1];
    end else if (paddr == `FFL_OFF_IDLE_SLOW) begin
      rd_word[`FFL_LO_MSB:`FFL_LO_LSB] = belt_fld[2];
    end else if (paddr == `FFL_OFF_ACT_FAST) begin
      rd_word[`FFL_HI_MSB:`FFL_HI_LSB] = belt_fld[3];
      rd_word[`FFL_LO_MSB:`FFL_LO_LSB] = belt_fld[4];
    end else if (paddr == `FFL_OFF_ACT_SLOW) begin
      rd_word[`FFL_LO_MSB:`FFL_LO_LSB] = belt_fld[5];
    end else begin
      hit = 1'b0;
    end
  end

  // Read data and error flag are captured at the setup edge
  always_comb begin
    prdata_nxt = prdata_r;
    perr_nxt = perr_r;
    if (setup) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_word;
      perr_nxt = !hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
      perr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      perr_r <= perr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pready && perr_r;

  // Sizing and watermarks; resizing is safe only with the path halted
  always_comb begin
    tx_end_nxt = tx_end_r;
    wm_on_nxt = wm_on_r;
    wm_off_nxt = wm_off_r;
    if (wr && paddr == `FFL_OFF_TX_END) begin
      tx_end_nxt = pwdata[`FFL_TX_END_MSB:0];
    end
    if (wr && paddr == `FFL_OFF_WMARK) begin
      wm_on_nxt = pwdata[`FFL_WM_ON_MSB:`FFL_WM_ON_LSB];
      wm_off_nxt = pwdata[`FFL_WM_OFF_MSB:`FFL_WM_OFF_LSB];
    end
    last_nxt = {tx_end_r, `FFL_BLK_TAIL};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_end_r <= `FFL_TX_END_RST;
      last_r <= {`FFL_TX_END_RST, `FFL_BLK_TAIL};
      wm_on_r <= 7'h00;
      wm_off_r <= 7'h00;
    end else begin
      tx_end_r <= tx_end_nxt;
      last_r <= last_nxt;
      wm_on_r <= wm_on_nxt;
      wm_off_r <= wm_off_nxt;
    end
  end

  assign tx_buffer_end_field = tx_end_r;
  assign tx_buffer_last_addr = last_r;

  // Receive buffer fill: length rounded up to doublewords, plus extras
  always_comb begin
    store_bytes = 16'(((rx_store_len + 16'h0003) & 16'hfffc) + {8'h00, rx_store_extra});
    fill_nxt = fill_r;
    if (rx_store) begin
      fill_nxt = 16'(fill_nxt + store_bytes);
    end
    if (rx_drain) begin
      fill_nxt = 16'(fill_nxt - rx_drain_bytes);
    end
  end

  assign fill_units = fill_r[15:`FFL_UNIT_LSB];

  // Hysteresis; on wins when both thresholds hold at once
  always_comb begin
    pause_nxt = pause_r;
    if (!pause_transmit_enable) begin
      pause_nxt = 1'b0;
    end else if (fill_units >= wm_on_r) begin
      pause_nxt = 1'b1;
    end else if (fill_units <= wm_off_r) begin
      pause_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_r <= 16'h0000;
      pause_r <= 1'b0;
    end else begin
      fill_r <= fill_nxt;
      pause_r <= pause_nxt;
    end
  end

  assign rx_buffer_fill_bytes = fill_r;
  assign pause_request = pause_r;

  // Software write strobes and data for the six tolerance fields
  always_comb begin
    belt_we[0] = wr && paddr == `FFL_OFF_IDLE_FAST;
    belt_we[1] = wr && paddr == `FFL_OFF_IDLE_FAST;
    belt_we[2] = wr && paddr == `FFL_OFF_IDLE_SLOW;
    belt_we[3] = wr && paddr == `FFL_OFF_ACT_FAST;
    belt_we[4] = wr && paddr == `FFL_OFF_ACT_FAST;
    belt_we[5] = wr && paddr == `FFL_OFF_ACT_SLOW;
    belt_wdata[0] = pwdata[`FFL_HI_MSB:`FFL_HI_LSB];
    belt_wdata[1] = pwdata[`FFL_LO_MSB:`FFL_LO_LSB];
    belt_wdata[2] = pwdata[`FFL_LO_MSB:`FFL_LO_LSB];
    belt_wdata[3] = pwdata[`FFL_HI_MSB:`FFL_HI_LSB];
    belt_wdata[4] = pwdata[`FFL_LO_MSB:`FFL_LO_LSB];
    belt_wdata[5] = pwdata[`FFL_LO_MSB:`FFL_LO_LSB];
  end

  // One field instance per tolerance value
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_belt
      ffl_belt_field u_field (
        .clk(clk),
        .rst(rst),
        .load(belt_load && belt_load_idx == 3'(gi)),
        .load_eeprom(belt_load_eeprom),
        .load_data(belt_load_data),
        .restore(restore),
        .sw_we(belt_we[gi]),
        .sw_data(belt_wdata[gi]),
        .value(belt_fld[gi])
      );
    end
  endgenerate

  // Tolerance selection by state and speed; unknown speed uses slow field
  always_comb begin
    belt_nxt = belt_fld[2];
    if (latency_state == ffl_pkg::FFL_LATENCY_IDLE_STATE) begin
      case (link_speed)
        ffl_pkg::FFL_SPD_1000: belt_nxt = belt_fld[0];
        ffl_pkg::FFL_SPD_100: belt_nxt = belt_fld[1];
        default: belt_nxt = belt_fld[2];
      endcase
    end else begin
      case (link_speed)
        ffl_pkg::FFL_SPD_1000: belt_nxt = belt_fld[3];
        ffl_pkg::FFL_SPD_100: belt_nxt = belt_fld[4];
        default: belt_nxt = belt_fld[5];
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      belt_r <= `FFL_BELT_RST;
    end else begin
      belt_r <= belt_nxt;
    end
  end

  assign belt_value = belt_r;

  // Checks
  sequence s_rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence s_wr_access(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence

  property p_last_addr;
    @(posedge clk) disable iff (rst)
    s_wr_access(`FFL_OFF_TX_END) ##2 1'b1 |->
      tx_buffer_last_addr == {$past(pwdata[5:0], 2), 7'h7f};
  endproperty
  a_last_addr: assert property (p_last_addr)
    else $error("buffer last address wrong after resize");

  property p_pause_on;
    @(posedge clk) disable iff (rst)
    pause_transmit_enable && fill_units >= wm_on_r |=> pause_request;
  endproperty
  a_pause_on: assert property (p_pause_on)
    else $error("pause not raised at on watermark");

  property p_pause_off;
    @(posedge clk) disable iff (rst)
    fill_units <= wm_off_r && fill_units < wm_on_r |=> !pause_request;
  endproperty
  a_pause_off: assert property (p_pause_off)
    else $error("pause not dropped at off watermark");

  property p_rx_occ;
    @(posedge clk) disable iff (rst)
    s_rd_setup(`FFL_OFF_RX_OCC) |=>
      prdata == {$past(usb_out_queue_fill) + $past(fill_r), $past(usb_out_queue_fill)};
  endproperty
  a_rx_occ: assert property (p_rx_occ)
    else $error("receive occupancy read wrong");

  property p_tx_occ;
    @(posedge clk) disable iff (rst)
    s_rd_setup(`FFL_OFF_TX_OCC) |=>
      prdata == {$past(usb_in_queue_fill) + $past(tx_buffer_fill), $past(usb_in_queue_fill)};
  endproperty
  a_tx_occ: assert property (p_tx_occ)
    else $error("transmit occupancy read wrong");

  property p_idle_gig;
    @(posedge clk) disable iff (rst)
    latency_state == ffl_pkg::FFL_LATENCY_IDLE_STATE && link_speed == ffl_pkg::FFL_SPD_1000
      |=> belt_value == $past(belt_fld[0]);
  endproperty
  a_idle_gig: assert property (p_idle_gig)
    else $error("idle gigabit tolerance not selected");

  property p_idle_slow;
    @(posedge clk) disable iff (rst)
    latency_state == ffl_pkg::FFL_LATENCY_IDLE_STATE && link_speed == ffl_pkg::FFL_SPD_10
      |=> belt_value == $past(belt_fld[2]);
  endproperty
  a_idle_slow: assert property (p_idle_slow)
    else $error("idle slow tolerance not selected");

  property p_act_fast;
    @(posedge clk) disable iff (rst)
    latency_state == ffl_pkg::FFL_LATENCY_ACTIVE_STATE && link_speed == ffl_pkg::FFL_SPD_100
      |=> belt_value == $past(belt_fld[4]);
  endproperty
  a_act_fast: assert property (p_act_fast)
    else $error("active fast tolerance not selected");

  property p_act_slow;
    @(posedge clk) disable iff (rst)
    latency_state == ffl_pkg::FFL_LATENCY_ACTIVE_STATE && link_speed == ffl_pkg::FFL_SPD_10
      |=> belt_value == $past(belt_fld[5]);
  endproperty
  a_act_slow: assert property (p_act_slow)
    else $error("active slow tolerance not selected");

  property p_fill_grow;
    @(posedge clk) disable iff (rst)
    rx_store && !rx_drain |=> rx_buffer_fill_bytes ==
      16'($past(fill_r) + (($past(rx_store_len) + 16'h0003) & 16'hfffc)
      + {8'h00, $past(rx_store_extra)});
  endproperty
  a_fill_grow: assert property (p_fill_grow)
    else $error("fill count grew by the wrong amount");

  property p_unit_scale;
    @(posedge clk) disable iff (rst)
    fill_r < 16'h0200 && wm_on_r == 7'h01 && wm_off_r == 7'h00 |=> !pause_request;
  endproperty
  a_unit_scale: assert property (p_unit_scale)
    else $error("watermark unit not 512 bytes");

endmodule

// [shared/ffl_pkg.sv]
// Types shared by the flow/latency register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ffl_pkg;

  // Link speed, Gray ordered from slow to gigabit
  typedef enum logic [1:0] {
    FFL_SPD_10 = 2'h0,
    FFL_SPD_100 = 2'h1,
    FFL_SPD_1000 = 2'h3
  } ffl_speed_t;

  // Latency power state
  typedef enum logic {
    FFL_LATENCY_IDLE_STATE = 1'h0,
    FFL_LATENCY_ACTIVE_STATE = 1'h1
  } ffl_ltm_t;

endpackage

// [shared/ffl_regs.svh]
// Register offsets, field positions, reset values for the flow/latency bank.
// Assumes an 8-bit APB byte address; each register is one aligned word.
`ifndef FFL_REGS_SVH
`define FFL_REGS_SVH

// Byte offsets
`define FFL_OFF_TX_END 8'hcc
`define FFL_OFF_WMARK 8'hd0
`define FFL_OFF_RX_OCC 8'hd4
`define FFL_OFF_TX_OCC 8'hd8
`define FFL_OFF_IDLE_FAST 8'he0
`define FFL_OFF_IDLE_SLOW 8'he4
`define FFL_OFF_ACT_FAST 8'he8
`define FFL_OFF_ACT_SLOW 8'hec

// Transmit buffer end field and block tail (128 doublewords per step)
`define FFL_TX_END_MSB 5
`define FFL_TX_END_RST 6'h17
`define FFL_BLK_TAIL 7'h7f

// Watermark fields, in 512-byte units
`define FFL_WM_ON_MSB 6
`define FFL_WM_ON_LSB 0
`define FFL_WM_OFF_MSB 14
`define FFL_WM_OFF_LSB 8
`define FFL_UNIT_LSB 9

// Tolerance fields
`define FFL_HI_MSB 27
`define FFL_HI_LSB 16
`define FFL_LO_MSB 11
`define FFL_LO_LSB 0
`define FFL_BELT_RST 12'h000

// Loader indices of the six tolerance fields
`define FFL_IX_IDLE_GIG 3'h0
`define FFL_IX_IDLE_FAST 3'h1
`define FFL_IX_IDLE_SLOW 3'h2
`define FFL_IX_ACT_GIG 3'h3
`define FFL_IX_ACT_FAST 3'h4
`define FFL_IX_ACT_SLOW 3'h5

`endif

// [test/tb.sv]
// Self-checking bench for the flow/latency register bank, APB side and pins.
// Assumes shared/ on the include path and ffl_pkg compiled before this file.
`timescale 1ns/10ps
`include "ffl_regs.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic usb_reset = 1'b0, lite_soft_reset = 1'b0, belt_load = 1'b0, belt_load_eeprom = 1'b0;
  logic [2:0] belt_load_idx = 3'h0;
  logic [11:0] belt_load_data = 12'h0;
  ffl_pkg::ffl_ltm_t latency_state = ffl_pkg::FFL_LATENCY_IDLE_STATE;
  ffl_pkg::ffl_speed_t link_speed = ffl_pkg::FFL_SPD_10;
  logic [11:0] belt_value;
  logic rx_store = 1'b0, rx_drain = 1'b0, pause_transmit_enable = 1'b0;
  logic [15:0] rx_store_len = 16'h0, rx_drain_bytes = 16'h0;
  logic [7:0] rx_store_extra = 8'h0;
  logic [15:0] usb_out_queue_fill = 16'h0, usb_in_queue_fill = 16'h0, tx_buffer_fill = 16'h0;
  logic pause_request;
  logic [15:0] rx_buffer_fill_bytes;
  logic [5:0] tx_buffer_end_field;
  logic [12:0] tx_buffer_last_addr;
  // Reference model state
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h5568;
  int fill_m = 0;
  logic [31:0] wm_m = 32'h0;
  logic [5:0] end_m = 6'h17;
  logic pause_m = 1'b0;
  logic [11:0] bv[6] = '{default: 12'h0};
  logic [11:0] img[6] = '{default: 12'h0};
  bit mem[6] = '{default: 1'b0};
  logic [7:0] addrs[8] = '{`FFL_OFF_TX_END, `FFL_OFF_WMARK, `FFL_OFF_RX_OCC, `FFL_OFF_TX_OCC,
    `FFL_OFF_IDLE_FAST, `FFL_OFF_IDLE_SLOW, `FFL_OFF_ACT_FAST, `FFL_OFF_ACT_SLOW};
  logic [31:0] q;
  logic e;

  ffl_config_regs dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_reset(usb_reset), .lite_soft_reset(lite_soft_reset), .belt_load(belt_load),
    .belt_load_eeprom(belt_load_eeprom), .belt_load_idx(belt_load_idx),
    .belt_load_data(belt_load_data), .latency_state(latency_state), .link_speed(link_speed),
    .belt_value(belt_value), .rx_store(rx_store), .rx_store_len(rx_store_len),
    .rx_store_extra(rx_store_extra), .rx_drain(rx_drain), .rx_drain_bytes(rx_drain_bytes),
    .usb_out_queue_fill(usb_out_queue_fill), .usb_in_queue_fill(usb_in_queue_fill),
    .tx_buffer_fill(tx_buffer_fill), .pause_transmit_enable(pause_transmit_enable),
    .pause_request(pause_request), .rx_buffer_fill_bytes(rx_buffer_fill_bytes),
    .tx_buffer_end_field(tx_buffer_end_field), .tx_buffer_last_addr(tx_buffer_last_addr)
  );

  // Bench clock, 8 ns period
  always #4 clk = ~clk;

  task summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Case equality so an unknown never matches
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready however long, the watchdog bounds it
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] reg_exp(input logic [7:0] a);
    case (a)
      `FFL_OFF_TX_END: return {26'h0, end_m};
      `FFL_OFF_WMARK: return wm_m;
      `FFL_OFF_RX_OCC: return {16'(usb_out_queue_fill + fill_m[15:0]), usb_out_queue_fill};
      `FFL_OFF_TX_OCC: return {16'(usb_in_queue_fill + tx_buffer_fill), usb_in_queue_fill};
      `FFL_OFF_IDLE_FAST: return {4'h0, bv[0], 4'h0, bv[1]};
      `FFL_OFF_IDLE_SLOW: return {20'h0, bv[2]};
      `FFL_OFF_ACT_FAST: return {4'h0, bv[3], 4'h0, bv[4]};
      `FFL_OFF_ACT_SLOW: return {20'h0, bv[5]};
      default: return 32'h0;
    endcase
  endfunction

  function automatic void set_pair(input int k, input logic [31:0] d);
    bv[k] = d[27:16];
    bv[k + 1] = d[11:0];
  endfunction

  // Write and mirror it; occupancy words are read-only and keep no state
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(e, 1'b0);
    case (a)
      `FFL_OFF_TX_END: end_m = d[5:0];
      `FFL_OFF_WMARK: wm_m = d & 32'h7f7f;
      `FFL_OFF_IDLE_FAST: set_pair(0, d);
      `FFL_OFF_IDLE_SLOW: bv[2] = d[11:0];
      `FFL_OFF_ACT_FAST: set_pair(3, d);
      `FFL_OFF_ACT_SLOW: bv[5] = d[11:0];
      default: ;
    endcase
  endtask

  task rd_all;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, addrs[i], 32'h0);
      chk(q, reg_exp(addrs[i]));
      chk(e, 1'b0);
    end
  endtask

  // Memory loads stick; a later one-time-memory load must lose
  task load(input int k, input logic [11:0] d, input logic ep);
    @(posedge clk);
    belt_load <= 1'b1;
    belt_load_idx <= k[2:0];
    belt_load_data <= d;
    belt_load_eeprom <= ep;
    @(posedge clk);
    belt_load <= 1'b0;
    if (ep || !mem[k]) begin
      img[k] = d;
      bv[k] = d;
    end
    mem[k] = mem[k] | ep;
  endtask

  task restore(input bit lite);
    @(posedge clk);
    if (lite)
      lite_soft_reset <= 1'b1;
    else
      usb_reset <= 1'b1;
    @(posedge clk);
    usb_reset <= 1'b0;
    lite_soft_reset <= 1'b0;
    bv = img;
  endtask

  // Every state and speed code, the unused code 2 counted as 10 Mbps
  task sel;
    for (int st = 0; st < 2; st++)
      for (int sp = 0; sp < 4; sp++) begin
        @(posedge clk);
        latency_state <= ffl_pkg::ffl_ltm_t'(st[0]);
        link_speed <= ffl_pkg::ffl_speed_t'(sp[1:0]);
        repeat (2) @(posedge clk);
        #1;
        chk(belt_value, bv[st * 3 + (sp == 3 ? 0 : sp == 1 ? 1 : 2)]);
      end
  endtask

  // Store or drain one frame, then compare fill and pause against the model
  task frame(input bit drain, input logic [15:0] n, input logic [7:0] x);
    @(posedge clk);
    rx_store <= !drain;
    rx_drain <= drain;
    rx_store_len <= n;
    rx_drain_bytes <= n;
    rx_store_extra <= x;
    @(posedge clk);
    rx_store <= 1'b0;
    rx_drain <= 1'b0;
    if (drain)
      fill_m = (fill_m - n) & 16'hffff;
    else
      fill_m = (fill_m + ((n + 3) & ~3) + x) & 16'hffff;
    repeat (2) @(posedge clk);
    #1;
    if (!pause_transmit_enable)
      pause_m = 1'b0;
    else if (fill_m / 512 >= wm_m[6:0])
      pause_m = 1'b1;
    else if (fill_m / 512 <= wm_m[14:8])
      pause_m = 1'b0;
    chk(rx_buffer_fill_bytes, fill_m[15:0]);
    chk(pause_request, pause_m);
  endtask

  // Hang guard, far beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    $display("unexpected at %0t: watchdog expired", $time);
    fail_count++;
    summarize;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(tx_buffer_end_field, 6'h17);
    chk(tx_buffer_last_addr, 13'hbff);
    rd_all;
    // Resize only while the transmit path is halted and empty
    wr(`FFL_OFF_TX_END, 32'h0000_000b);
    @(posedge clk);
    #1;
    chk(tx_buffer_last_addr, 13'h05ff);
    // Random images in every word, read-only ones included
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      usb_out_queue_fill <= 16'($random(seed));
      usb_in_queue_fill <= 16'($random(seed));
      tx_buffer_fill <= 16'($random(seed));
      for (int i = 0; i < 8; i++) wr(addrs[i], $random(seed));
      #1;
      chk(tx_buffer_end_field, end_m);
      chk(tx_buffer_last_addr, {end_m, 7'h7f});
      rd_all;
    end
    // Nothing loaded yet, so a restore clears the tolerances
    restore(1'b0);
    rd_all;
    // Unmapped word: error, no data
    apb(1'b1, 8'hdc, 32'hffffffff);
    chk(e, 1'b1);
    apb(1'b0, 8'hdc, 32'h0);
    chk(q, 32'h0);
    chk(e, 1'b1);
    // One-time memory, then mixed memory loads, then one-time again
    for (int k = 0; k < 6; k++) load(k, 12'($random(seed)), 1'b0);
    for (int k = 0; k < 6; k++) load(k, 12'($random(seed)), k[0]);
    for (int k = 0; k < 6; k++) load(k, 12'($random(seed)), 1'b0);
    rd_all;
    sel;
    // Software overwrite, then each reset kind brings the image back
    for (int t = 0; t < 2; t++) begin
      for (int i = 4; i < 8; i++) wr(addrs[i], $random(seed));
      sel;
      restore(t[0]);
      rd_all;
      sel;
    end
    // One-unit on-watermark: 508 bytes stay below it, 512 reach it
    wr(`FFL_OFF_WMARK, 32'h0001);
    @(posedge clk);
    pause_transmit_enable <= 1'b1;
    frame(1'b0, 16'd508, 8'h0);
    frame(1'b0, 16'd4, 8'h0);
    frame(1'b1, 16'd512, 8'h0);
    // Pause generation off again before the thresholds change
    @(posedge clk);
    pause_transmit_enable <= 1'b0;
    // Watermarks first, then enable; exact boundary steps
    wr(`FFL_OFF_WMARK, 32'h0204);
    @(posedge clk);
    pause_transmit_enable <= 1'b1;
    frame(1'b0, 16'd2044, 8'h0);
    frame(1'b0, 16'd4, 8'h0);
    frame(1'b1, 16'd512, 8'h0);
    frame(1'b1, 16'd4, 8'h0);
    frame(1'b0, 16'd1, 8'h0);
    for (int i = 0; i < 40; i++)
      if (fill_m > 4000)
        frame(1'b1, 16'(fill_m / 2), 8'h0);
      else
        frame(1'b0, 16'($random(seed)) & 16'h3ff, 8'($random(seed)) & 8'h1c);
    // Enable dropped with the buffer still full
    @(posedge clk);
    pause_transmit_enable <= 1'b0;
    frame(1'b0, 16'd0, 8'h0);
    summarize;
  end
endmodule
